/* File: rtl/dpr_pkg.sv */
// Constants, register map and field layout of the digital port block
package dpr_pkg;

    // Clock rates; the port clock cannot exceed half of sys_clk here
    localparam int unsigned SYS_CLK_HZ     = 20_000_000;
    localparam int unsigned PORT_CLK_HZ    = 56_250_000;
    localparam int unsigned PORT_HALF_RAW  = SYS_CLK_HZ / (2 * PORT_CLK_HZ);
    localparam int unsigned PORT_HALF_CYC  =
        (PORT_HALF_RAW == 0) ? 1 : PORT_HALF_RAW;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_DECIM = 8'h04;
    localparam logic [7:0] REG_OUT   = 8'h08;
    localparam logic [7:0] REG_IN    = 8'h0c;
    localparam logic [7:0] REG_STAT  = 8'h10;

    // Control register fields
    localparam int unsigned CTRL_DRIVE_LSB = 0;
    localparam int unsigned CTRL_MODE_BIT  = 4;
    localparam int unsigned CTRL_CLKSEL_BIT = 5;

    // Reset values
    localparam logic [31:0] DECIM_RST = 32'h0055_d4a8; // 5625000
    localparam logic [31:0] OUT_RST   = 32'h0000_0000;

    // Result mode bit positions on the port lines
    localparam int unsigned NUM_BYTES    = 4;
    localparam int unsigned NUM_PATHS    = 10;
    localparam int unsigned RES_VALID_LO = 0;
    localparam int unsigned RES_CW_LSB   = 1;
    localparam int unsigned RES_RSV_LSB  = 11;
    localparam int unsigned RES_RSV_MSB  = 13;
    localparam int unsigned RES_VALID_HI = 14;
    localparam int unsigned RES_STROBE   = 15;

    // Result FIFO
    localparam int unsigned FIFO_DEPTH = 4;

    // Operating modes of the port
    typedef enum logic {
        MODE_MANUAL = 1'b0,
        MODE_RESULT = 1'b1
    } dpr_mode_e;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* File: rtl/dpr_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dpr_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic                        not_full;
    } dpr_fifo_s;

    dpr_fifo_s st_q;
    dpr_fifo_s st_d;
    logic      push;
    logic      pop;

    always_comb begin
        st_d = st_q;
        push = in_valid && st_q.not_full;
        pop  = out_ready && (st_q.count != '0);
        if (push) begin
            st_d.mem[st_q.wr_ptr] = in_data;
            st_d.wr_ptr = (st_q.wr_ptr == AW'(DEPTH - 1)) ? '0
                                                          : st_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_d.rd_ptr = (st_q.rd_ptr == AW'(DEPTH - 1)) ? '0
                                                          : st_q.rd_ptr + 1'b1;
        end
        st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
        // Registered so that ready does not ripple back from the drain side
        st_d.not_full = (st_d.count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign in_ready  = st_q.not_full;
    assign out_valid = (st_q.count != '0);
    assign out_data  = st_q.mem[st_q.rd_ptr];

endmodule // dpr_fifo
`default_nettype wire

/* File: rtl/dpr_port.sv */
// Digital I/O port with result output mode and AXI4-Lite registers
// Operation
// R1: 32 lines in four bytes, each byte input or output by drive bit.
// R2: Output lines update together on the port clock falling edge.
// R3: Port clock is driven out on the output latch clock pin.
// R4: Input sampling clock selected between port clock and external clock.
// R5: Count selected clock edges to decimation value, then latch inputs.
// R6: Decimation value resets to 5625000.
// R7: Far side may clock inputs and outputs with its own external clock; here it clocks input sampling only, outputs stay on the port clock.
// R8: Result mode drives codeword valid on bit 0 and bit 14.
// R9: Result mode drives the ten path results on bits 10 down to 1.
// R10: Result mode drives a toggling alignment strobe on bit 15.
// R11: Results routed only in result mode with lower bytes driven.
// R12: Reserved bits 13 to 11 driven low in result mode.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module dpr_port
    import dpr_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Result codeword stream from the readout paths
    input  wire logic [NUM_PATHS-1:0] result_codeword,
    input  wire logic                 result_valid,
    output logic                      result_ready,
    // Port pins
    input  wire logic [31:0]          port_lines_i,
    output logic [31:0]               port_lines_o,
    output logic [31:0]               port_lines_oe,
    output logic                      output_latch_clock_out,
    input  wire logic                 ext_sample_clock_in
);

    typedef struct packed {
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_s3;
        logic [31:0] pin_s1;
        logic [31:0] pin_s2;
        logic [3:0]  div_cnt;
        logic        latch_clk;
        logic [3:0]  drive;
        logic        mode;
        logic        clksel;
        logic [31:0] decim;
        logic [31:0] out_reg;
        logic [31:0] in_data;
        logic [31:0] dec_cnt;
        logic [15:0] sample_cnt;
        logic [31:0] pins_out;
        logic [31:0] pins_oe;
        logic        strobe;
        logic        res_on;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awrdy;
        logic        wrdy;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arrdy;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        fifo_rdy;
    } dpr_state_s;

    localparam dpr_state_s STATE_RST = '{
        decim:   DECIM_RST,
        out_reg: OUT_RST,
        default: '0
    };

    dpr_state_s           st_q;
    dpr_state_s           st_d;
    logic [31:0]          oe_exp;
    logic                 port_fall;
    logic                 port_rise;
    logic                 ext_edge;
    logic                 sample_tick;
    logic                 dec_hit;
    logic                 result_en;
    logic                 fifo_pop;
    logic                 fifo_rdy;
    logic [NUM_PATHS-1:0] fifo_data;
    logic                 fifo_valid;
    logic [31:0]          ctrl_word;
    logic [31:0]          wr_merge;
    logic [7:0]           wr_addr;
    logic [7:0]           rd_addr;

    // Byte lanes of the drive setting become per-line enables
    for (genvar b = 0; b < NUM_BYTES; b++) begin : g_drive
        assign oe_exp[8*b +: 8] = {8{st_q.drive[b]}}; // R1
    end

    assign ctrl_word = {26'h0, st_q.clksel, st_q.mode, st_q.drive};

    // Readout results wait here until a port clock falling edge with results enabled
    dpr_fifo #(
        .WIDTH (NUM_PATHS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (sys_clk),
        .resetn    (resetn),
        .in_data   (result_codeword),
        .in_valid  (result_valid),
        .in_ready  (fifo_rdy),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    always_comb begin
        st_d = st_q;
        // Pins from outside pass two flops before use
        st_d.ext_s1 = ext_sample_clock_in;
        st_d.ext_s2 = st_q.ext_s1;
        st_d.ext_s3 = st_q.ext_s2;
        st_d.pin_s1 = port_lines_i;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.fifo_rdy = fifo_rdy;

        // Port clock generator; its falling edge is the output update point
        port_fall = 1'b0;
        port_rise = 1'b0;
        if (st_q.div_cnt == 4'(PORT_HALF_CYC - 1)) begin
            st_d.div_cnt   = '0;
            st_d.latch_clk = ~st_q.latch_clk; // R3
            port_fall      = st_q.latch_clk;
            port_rise      = ~st_q.latch_clk;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 4'h1;
        end

        // Results need result mode and both lower bytes as outputs
        result_en = (st_q.mode == MODE_RESULT) && (&st_q.drive[1:0]); // R11
        fifo_pop  = port_fall && result_en && fifo_valid;

        if (port_fall) begin
            st_d.pins_oe = oe_exp; // R1
            st_d.res_on  = result_en;
            if (result_en) begin
                st_d.strobe = ~st_q.strobe; // R10
                st_d.pins_out = st_q.out_reg; // R2
                st_d.pins_out[RES_VALID_LO] = fifo_valid; // R8
                st_d.pins_out[RES_VALID_HI] = fifo_valid; // R8
                st_d.pins_out[RES_CW_LSB +: NUM_PATHS] =
                    fifo_valid ? fifo_data : '0; // R9
                st_d.pins_out[RES_RSV_MSB:RES_RSV_LSB] = '0; // R12
                st_d.pins_out[RES_STROBE] = ~st_q.strobe; // R10
            end else begin
                st_d.strobe   = 1'b0;
                st_d.pins_out = st_q.out_reg; // R2
            end
        end

        // Input sampling on the selected clock, decimated
        ext_edge    = st_q.ext_s2 && !st_q.ext_s3;
        sample_tick = st_q.clksel ? ext_edge : port_rise; // R4
        // A decimation of zero behaves as one
        dec_hit = (st_q.decim == '0) ||
                  (st_q.dec_cnt >= st_q.decim - 32'h1);
        if (sample_tick) begin
            if (dec_hit) begin
                st_d.dec_cnt    = '0;
                st_d.in_data    = st_q.pin_s2; // R5
                st_d.sample_cnt = st_q.sample_cnt + 16'h1;
            end else begin
                st_d.dec_cnt = st_q.dec_cnt + 32'h1; // R5
            end
        end

        // AXI4-Lite write channel; address and data may come in any order
        if (s_axi_awvalid && st_q.awrdy) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_q.wrdy) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        wr_addr  = {st_d.awaddr[7:2], 2'b00};
        wr_merge = 32'h0;
        if (st_d.aw_got && st_d.w_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = RESP_OKAY;
            unique case (wr_addr)
                REG_CTRL: begin
                    wr_merge = merge_bytes(ctrl_word, st_d.wdata,
                                           st_d.wstrb);
                    st_d.drive  = wr_merge[CTRL_DRIVE_LSB +: NUM_BYTES];
                    st_d.mode   = wr_merge[CTRL_MODE_BIT];
                    st_d.clksel = wr_merge[CTRL_CLKSEL_BIT];
                    // Restart decimation so a new clock starts clean
                    st_d.dec_cnt = '0;
                end
                REG_DECIM: begin
                    st_d.decim = merge_bytes(st_q.decim, st_d.wdata,
                                             st_d.wstrb);
                    st_d.dec_cnt = '0;
                end
                REG_OUT: begin
                    st_d.out_reg = merge_bytes(st_q.out_reg, st_d.wdata,
                                               st_d.wstrb);
                end
                REG_IN, REG_STAT: begin
                    st_d.bresp = RESP_OKAY;
                end
                default: begin
                    st_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        st_d.awrdy = !st_d.aw_got && !st_d.bvalid;
        st_d.wrdy  = !st_d.w_got && !st_d.bvalid;

        // AXI4-Lite read channel
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        rd_addr = {s_axi_araddr[7:2], 2'b00};
        if (s_axi_arvalid && st_q.arrdy) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = RESP_OKAY;
            unique case (rd_addr)
                REG_CTRL:  st_d.rdata = ctrl_word;
                REG_DECIM: st_d.rdata = st_q.decim;
                REG_OUT:   st_d.rdata = st_q.out_reg;
                REG_IN:    st_d.rdata = st_q.in_data;
                REG_STAT:  st_d.rdata = {st_q.sample_cnt, 13'h0,
                                         fifo_valid, !st_q.fifo_rdy,
                                         st_q.res_on};
                default: begin
                    st_d.rdata = 32'h0;
                    st_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        st_d.arrdy = !st_d.rvalid;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= STATE_RST; // R6
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready          = st_q.awrdy;
    assign s_axi_wready           = st_q.wrdy;
    assign s_axi_bvalid           = st_q.bvalid;
    assign s_axi_bresp            = st_q.bresp;
    assign s_axi_arready          = st_q.arrdy;
    assign s_axi_rvalid           = st_q.rvalid;
    assign s_axi_rdata            = st_q.rdata;
    assign s_axi_rresp            = st_q.rresp;
    assign result_ready           = fifo_rdy;
    assign port_lines_o           = st_q.pins_out;
    assign port_lines_oe          = st_q.pins_oe;
    assign output_latch_clock_out = st_q.latch_clk;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Enables follow the drive bits byte-wise after each falling edge
    oe_byte_a: assert property (port_fall |=> // R1
            port_lines_oe == $past(oe_exp))
        else $error("port enables do not follow drive bytes");

    // Outputs never move except just after a port clock falling edge
    out_on_fall_a: assert property ($changed(port_lines_o) |-> // R2
            $past(port_fall) && !output_latch_clock_out)
        else $error("port lines changed off the falling edge");

    latch_clk_a: assert property (port_fall |=> // R3
            !output_latch_clock_out ##1 output_latch_clock_out)
        else $error("latch clock pin does not follow port clock");

    clk_select_a: assert property ( // R4
            $past(st_q.clksel) && $changed(st_q.in_data) |-> $past(ext_edge))
        else $error("external sample taken without external edge");

    decim_latch_a: assert property ( // R5
            sample_tick && dec_hit |=>
            st_q.sample_cnt == $past(st_q.sample_cnt) + 16'h1 &&
            st_q.dec_cnt == '0)
        else $error("decimation hit did not latch inputs");

    decim_reset_a: assert property ( // R6
            $past(!resetn) |-> st_q.decim == DECIM_RST)
        else $error("decimation value wrong after reset");

    valid_pair_a: assert property (st_q.res_on |-> // R8
            port_lines_o[RES_VALID_LO] == port_lines_o[RES_VALID_HI])
        else $error("valid copies disagree");

    cw_map_a: assert property (fifo_pop |=> // R9
            port_lines_o[RES_CW_LSB +: NUM_PATHS] == $past(fifo_data) &&
            port_lines_o[RES_VALID_LO])
        else $error("codeword not placed on result lines");

    strobe_a: assert property (port_fall && result_en && st_q.res_on |=> // R10
            port_lines_o[RES_STROBE] != $past(port_lines_o[RES_STROBE]))
        else $error("alignment strobe did not toggle");

    route_a: assert property (port_fall && !result_en |=> // R11
            port_lines_o == $past(st_q.out_reg))
        else $error("result routed while not enabled");

    rsvd_low_a: assert property (st_q.res_on |-> // R12
            port_lines_o[RES_RSV_MSB:RES_RSV_LSB] == 3'h0)
        else $error("reserved result bits not low");

    result_pop_c: cover property (fifo_pop ##[1:4] fifo_pop);
    ext_sample_c: cover property (st_q.clksel && sample_tick && dec_hit);
    fifo_full_c:  cover property (result_valid && !result_ready);
    axi_write_c:  cover property (s_axi_bvalid && s_axi_bready);

endmodule // dpr_port
`default_nettype wire

/* File: sim/dpr_far_end.sv */
// Far-side instrument logic: drives input lines, clocks and samples the port
`timescale 1ns/1ns
`default_nettype none
module dpr_far_end (
    // Port pins
    input  wire logic [31:0] port_lines_o,
    input  wire logic [31:0] port_lines_oe,
    output logic [31:0]      port_lines_i,
    input  wire logic        output_latch_clock_out,
    output logic             ext_sample_clock_in,
    // Bench control
    input  wire logic [31:0] far_val,
    input  wire logic        ext_run,
    input  wire logic        cap_en
);
    logic [31:0] words[$];

    // Each line carries whichever party drives it
    assign port_lines_i = (port_lines_o & port_lines_oe)
                        | (far_val & ~port_lines_oe);

    // Own sample clock, 400 ns; a stop finishes the high phase, parks low
    initial begin
        ext_sample_clock_in = 1'b0;
        forever begin
            #200;
            if (ext_run || ext_sample_clock_in) begin
                ext_sample_clock_in = ~ext_sample_clock_in;
            end
        end
    end

    // Sample mid-period, where the outputs are settled
    always @(posedge output_latch_clock_out) begin
        if (cap_en) begin
            words.push_back(port_lines_i);
        end
    end
endmodule // dpr_far_end
`default_nettype wire

/* File: sim/digital_io_port_result_output_test.sv */
// Self-checking bench for the digital port block
`timescale 1ns/1ns
`default_nettype none
module digital_io_port_result_output_test
    import dpr_pkg::*;
;
    logic        sys_clk, resetn, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, w, far_val, prev_o;
    logic [31:0] port_lines_i, port_lines_o, port_lines_oe;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] cnt0;
    logic [NUM_PATHS-1:0] result_codeword;
    logic        result_valid, result_ready, output_latch_clock_out;
    logic        ext_sample_clock_in, ext_run, cap_en, saw_full;
    logic        prev_latch, prevstb;
    int          n_mismatch, comparisons, run_cyc, k;

    dpr_port u_dpr_port (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .result_codeword,
        .result_valid, .result_ready, .port_lines_i, .port_lines_o,
        .port_lines_oe, .output_latch_clock_out, .ext_sample_clock_in);

    dpr_far_end u_dpr_far_end (.port_lines_o, .port_lines_oe, .port_lines_i,
        .output_latch_clock_out, .ext_sample_clock_in, .far_val, .ext_run,
        .cap_en);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Entered right after a rising edge; each channel held until taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        do @(posedge sys_clk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask

    task automatic axi_read(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    // Valid stays up across calls, so back-to-back pushes need no gap
    task automatic push(input logic [NUM_PATHS-1:0] c);
        result_codeword <= c;
        result_valid    <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (!result_ready) begin
                saw_full = 1'b1;
            end
        end while (!result_ready);
    endtask

    function automatic logic [NUM_PATHS-1:0] cw_of(input int i);
        return 10'h155 + 10'(i * 123);
    endfunction

    // Latch clock must toggle each cycle; outputs move only as it falls
    always @(negedge sys_clk) begin
        if (!resetn) begin
            run_cyc = 0;
        end else begin
            run_cyc++;
            if (run_cyc > 2) begin
                check({31'h0, output_latch_clock_out ^ prev_latch}, 32'h1);
                if (port_lines_o !== prev_o) begin
                    check({31'h0, prev_latch & ~output_latch_clock_out},
                          32'h1);
                end
            end
        end
        prev_latch = output_latch_clock_out;
        prev_o = port_lines_o;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        // Response ready stays high throughout, so no task ever toggles it
        {s_axi_bready, s_axi_rready} = 2'b11;
        {result_valid, ext_run, cap_en, saw_full} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, far_val} = '0;
        result_codeword = '0;
        s_axi_wstrb = 4'hf;
        resetn = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        axi_read(REG_CTRL);
        check(rd, 32'h0);
        axi_read(REG_DECIM);
        check(rd, 32'h0055_d4a8);
        check(port_lines_oe, 32'h0);
        axi_read(8'h14);
        check({30'h0, rsp}, {30'h0, RESP_SLVERR});
        far_val <= 32'h1234_5678;
        axi_write(REG_OUT, 32'ha5c3_3c5a);
        axi_write(REG_DECIM, 32'h3);
        axi_write(REG_CTRL, 32'h5);
        repeat (40) @(posedge sys_clk);
        check(port_lines_oe, 32'h00ff_00ff);
        check(port_lines_o & port_lines_oe, 32'h00c3_005a);
        axi_read(REG_IN);
        check(rd, 32'h12c3_565a);
        axi_read(REG_STAT);
        cnt0 = rd[31:16];
        repeat (60) @(posedge sys_clk);
        axi_read(REG_STAT);
        cnt0 = rd[31:16] - cnt0;
        check({31'h0, cnt0 >= 16'd10 && cnt0 <= 16'd11}, 32'h1);
        axi_write(REG_CTRL, 32'h20);
        axi_write(REG_DECIM, 32'h2);
        far_val <= 32'hcafe_f00d;
        ext_run <= 1'b1;
        repeat (80) @(posedge sys_clk);
        axi_read(REG_IN);
        check(rd, 32'hcafe_f00d);
        ext_run <= 1'b0;
        far_val <= 32'h0;
        axi_write(REG_IN, 32'h0);
        check({30'h0, rsp}, {30'h0, RESP_OKAY});
        repeat (80) @(posedge sys_clk);
        axi_read(REG_IN);
        check(rd, 32'hcafe_f00d);
        axi_write(REG_OUT, 32'hbeef_0000);
        axi_write(REG_CTRL, 32'h13);
        repeat (4) @(posedge sys_clk);
        cap_en <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            push(cw_of(i));
        end
        result_valid <= 1'b0;
        repeat (40) @(posedge sys_clk);
        cap_en <= 1'b0;
        check({31'h0, saw_full}, 32'h1);
        k = 0;
        for (int j = 0; j < u_dpr_far_end.words.size(); j++) begin
            w = u_dpr_far_end.words[j];
            check({31'h0, w[RES_VALID_LO]}, {31'h0, w[RES_VALID_HI]});
            check({29'h0, w[RES_RSV_MSB:RES_RSV_LSB]}, 32'h0);
            if (j > 0) begin
                check({31'h0, w[RES_STROBE] ^ prevstb}, 32'h1);
            end
            if (w[RES_VALID_LO]) begin
                check({22'h0, w[10:1]}, {22'h0, cw_of(k)});
                k++;
            end else begin
                check({22'h0, w[10:1]}, 32'h0);
            end
            prevstb = w[RES_STROBE];
        end
        check(32'(k), 32'd12);
        // A codeword waiting while only byte 0 drives must stay off the pins
        axi_write(REG_CTRL, 32'h11);
        axi_write(REG_OUT, 32'h0000_1234);
        push(10'h3ff);
        result_valid <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check(port_lines_o, 32'h0000_1234);
        axi_read(REG_STAT);
        check({29'h0, rd[2:0]}, 32'h4);
        give_verdict();
    end
endmodule // digital_io_port_result_output_test
`default_nettype wire
